/* rxps_host_model.sv */
// Host controller model that writes frames on the serial control port.
// Assumes one caller at a time; the link clock stands still between frames.
`timescale 1ns/1ns
module rxps_host_model (
    output logic o_ctl_clk,
    output logic o_ctl_ce,
    output logic o_ctl_di
);
    // Idle: enable low, clock parked low
    initial begin
        o_ctl_clk = 1'b0;
        o_ctl_ce = 1'b0;
        o_ctl_di = 1'b0;
    end
    // Address, command and data bytes, each LSB first, on a 125 ns link clock
    task automatic send(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d);
        logic [23:0] f;
        f = {d, c, a};
        o_ctl_ce = 1'b1;
        for (int i = 0; i < 24; i++) begin
            o_ctl_di = f[i];
            #63 o_ctl_clk = 1'b1;
            #62 o_ctl_clk = 1'b0;
        end
        #31 o_ctl_ce = 1'b0;
        // A released line shows the opposite of the last bit, never a held value
        o_ctl_di = ~f[23];
        // Gap well above the four main-clock cycles needed between frames
        #500;
    endtask
endmodule

/* rxps_pkg.sv */
// Constants, field layouts, state codes and carriers for the receiver port
// select and output format block.
// Assumes a 10 MHz main clock and a serial control port of 24 bits per frame.
// Functional notes
// - Clock source switches keep the error flag with the amp continuous or fs masked.
// - Otherwise the error flag is raised for the whole clock source switch.
// - Serial input data is taken in with a clock synchronised to that data.
// - Switching to crystal while the PLL is locked leaves the lock state untouched.
// - Auto amp-stop mode waits for stable oscillation, then switches clock and data together.
// - Input select codes 0-6 pick biphase inputs, 7 the modulator; reset 0.
// - Code 4 takes validity input, code 5 user input, when their pin options are set.
// - Unlock input switch bit set lets the input move on PLL unlock; reset 0.
// - Pass-through codes 0-6 drive inputs, 7 the modulator; reset 0.
// - Pass-through disable bit holds the pass-through output low; reset 0.
// - Format 0 I2S, 1 left-justified, 2-4 right-justified master only, 5-7 reserved.
// - Primary bit-clock polarity 0 changes data on falling edge, 1 on rising.
// - Primary word-select polarity 1 swaps left and right halves; reset 0.
// - Secondary bit-clock polarity defaults 0; both values change data on falling edge.
// - Secondary word-select polarity 1 swaps left and right halves; reset 0.
// - Output format and primary word-select polarity are set independently.
// - Amp mode 00 auto stop at lock, 01 continuous, 11 stop, 10 reserved.
// - Source bit 0 uses crystal only while unlocked; 1 uses crystal always.
// - Fs-change mask bit 1 keeps fs changes off the error flag; reset 0.
package rxps_pkg;

    // Serial frame layout: chip address byte, command byte, data byte
    localparam int RXPS_FRAME_BITS = 24;
    localparam logic [3:0] RXPS_CMD_PORT_SEL = 4'h6;
    localparam logic [3:0] RXPS_CMD_FMT_POL = 4'h7;

    // Port select register fields
    localparam int RXPS_DSEL_LSB = 0;
    localparam int RXPS_ULSW_BIT = 3;
    localparam int RXPS_PSEL_LSB = 4;
    localparam int RXPS_PDIS_BIT = 7;
    localparam logic [7:0] RXPS_PORT_SEL_RST = 8'h00;

    // Format and polarity register fields
    localparam int RXPS_OFMT_LSB = 0;
    localparam int RXPS_PBCK_BIT = 4;
    localparam int RXPS_PWS_BIT = 5;
    localparam int RXPS_SCLKP_BIT = 6;
    localparam int RXPS_SWS_BIT = 7;
    localparam logic [7:0] RXPS_FMT_POL_RST = 8'h00;

    // Oscillation amplifier modes
    localparam logic [1:0] RXPS_AMP_AUTO = 2'h0;
    localparam logic [1:0] RXPS_AMP_CONT = 2'h1;
    localparam logic [1:0] RXPS_AMP_STOP = 2'h3;

    // Output format codes, modulator select code and last pin index
    localparam logic [2:0] RXPS_FMT_I2S = 3'h0;
    localparam logic [2:0] RXPS_FMT_LJ = 3'h1;
    localparam logic [2:0] RXPS_FMT_RJ16 = 3'h4;
    localparam logic [2:0] RXPS_SEL_MOD = 3'h7;
    localparam logic [2:0] RXPS_LAST_PIN = 3'h6;

    // Timing
    localparam int RXPS_MCLK_KHZ = 10000;
    localparam int RXPS_SWITCH_TIME_NS = 500;
    localparam int RXPS_SCAN_TIME_US = 100;
    localparam int RXPS_SWITCH_CYCLES = (RXPS_SWITCH_TIME_NS * RXPS_MCLK_KHZ + 999999) / 1000000;
    localparam int RXPS_SCAN_CYCLES = (RXPS_SCAN_TIME_US * RXPS_MCLK_KHZ) / 1000;

    // Clock source sequencer states
    typedef enum logic [1:0] {
        RXPS_CS_PLL,
        RXPS_CS_WAIT_OSC,
        RXPS_CS_SWITCH,
        RXPS_CS_XTAL
    } rxps_cs_t;

    // Settings owned by neighbouring command registers
    typedef struct packed {
        logic [1:0] osc_amp_mode;
        logic fs_change_error_mask;
        logic out_clk_source_sel;
        logic primary_clk_source_sel;
        logic clk_switch_method;
        logic validity_pin_option;
        logic user_pin_option;
        logic master_mode;
    } rxps_cfg_t;

    // Effective serial output format towards the audio output stage
    typedef struct packed {
        logic [2:0] format;
        logic format_valid;
        logic primary_bit_rise;
        logic primary_ws_swap;
        logic secondary_bit_rise;
        logic secondary_ws_swap;
    } rxps_fmt_t;

endpackage

/* rxps_top.sv */
// Port selection, pass-through routing, output format and clock source
// switching of the receiver, with its serial control port.
// Assumes the host keeps the control clock still while chip enable is low,
// and that PLL, oscillator and error sources run on i_mclk.
`timescale 1ns/1ns
module rxps_top
    import rxps_pkg::*;
#(
    parameter logic [7:0] CHIP_ADDR = 8'hE8,
    parameter logic [1:0] CHIP_SUB = 2'h0,
    parameter int TMR_W = 16
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_ctl_clk,
    input wire logic i_ctl_ce,
    input wire logic i_ctl_di,
    input wire logic [6:0] i_biphase_in,
    input wire logic i_modulator_out,
    input wire logic i_pll_locked,
    input wire logic i_osc_stable,
    input wire logic i_fs_change,
    input wire logic i_base_error,
    input wire rxps_cfg_t i_cfg,
    output logic o_demod_in,
    output logic [2:0] o_demod_sel,
    output logic o_passthrough_out,
    output rxps_fmt_t o_fmt,
    output logic o_clk_src_xtal,
    output logic o_data_src_serial,
    output logic o_serial_capture_sync,
    output logic o_receive_error_flag,
    output logic o_pll_locked,
    output logic [7:0] o_port_sel_reg,
    output logic [7:0] o_fmt_pol_reg
);

    // Counts must fit the timer
    initial begin
        if (TMR_W < 2 || RXPS_SCAN_CYCLES >= (1 << TMR_W) || RXPS_SWITCH_CYCLES < 1) begin
            $error("rxps_top: timer width too small for the configured counts");
        end
    end

    localparam logic [TMR_W-1:0] SWITCH_LOAD = TMR_W'(RXPS_SWITCH_CYCLES - 1);
    localparam logic [TMR_W-1:0] SCAN_LOAD = TMR_W'(RXPS_SCAN_CYCLES - 1);

    // Link-side state: only the frame shift register
    typedef struct packed {
        logic [RXPS_FRAME_BITS-1:0] sr;
    } rxps_lnk_t;

    // Core-side state
    typedef struct packed {
        logic ce_s1;
        logic ce_s2;
        logic ce_s3;
        logic [6:0] bp_s1;
        logic [6:0] bp_s2;
        logic [7:0] port_sel;
        logic [7:0] fmt_pol;
        rxps_cs_t cs;
        logic tgt_xtal;
        logic [TMR_W-1:0] tmr;
        logic [2:0] scan_ofs;
        logic [TMR_W-1:0] scan_tmr;
        logic demod_in;
        logic [2:0] demod_sel;
        logic pt_out;
        rxps_fmt_t fmt;
        logic clk_xtal;
        logic data_serial;
        logic err;
        logic locked;
    } rxps_st_t;

    rxps_lnk_t lnk_r;
    rxps_lnk_t lnk_nxt;
    rxps_st_t st_r;
    rxps_st_t st_nxt;

    // Demodulator input mux, codes 4 and 5 take shared pins 5 and 6 when their pin options are set
    function automatic logic demod_mux(input logic [2:0] code, input logic [6:0] pins,
                                       input logic modo, input rxps_cfg_t cfg);
        logic v;
        v = 1'b0;
        unique case (code)
            3'h4: v = cfg.validity_pin_option ? pins[5] : pins[4];
            3'h5: v = cfg.user_pin_option ? pins[6] : pins[5];
            RXPS_SEL_MOD: v = modo;
            default: v = pins[code];
        endcase
        return v;
    endfunction

    // Shift bits in while chip enable is high; the last 24 bits form the frame.
    // No reset here: the control clock may be still during reset.
    always_comb begin
        lnk_nxt = lnk_r;
        if (i_ctl_ce) begin
            lnk_nxt.sr = {i_ctl_di, lnk_r.sr[RXPS_FRAME_BITS-1:1]};
        end
    end

    always_ff @(posedge i_ctl_clk) begin
        lnk_r <= lnk_nxt;
    end

    // Core logic on the main clock
    always_comb begin
        logic frame_end;
        logic cmd_ok;
        logic [7:0] addr_b;
        logic [7:0] cmd_b;
        logic [7:0] data_b;
        logic want_xtal;
        logic force_xtal;
        logic keep_err;
        logic sw_err;
        logic ulsw;
        logic [2:0] base_sel;
        logic [2:0] psel;
        logic [3:0] sum;
        logic [2:0] fmt_code;
        frame_end = 1'b0;
        cmd_ok = 1'b0;
        addr_b = 8'h00;
        cmd_b = 8'h00;
        data_b = 8'h00;
        want_xtal = 1'b0;
        force_xtal = 1'b0;
        keep_err = 1'b0;
        sw_err = 1'b0;
        ulsw = 1'b0;
        base_sel = 3'h0;
        psel = 3'h0;
        sum = 4'h0;
        fmt_code = 3'h0;
        st_nxt = st_r;

        // Pin synchronisers
        st_nxt.ce_s1 = i_ctl_ce;
        st_nxt.ce_s2 = st_r.ce_s1;
        st_nxt.ce_s3 = st_r.ce_s2;
        st_nxt.bp_s1 = i_biphase_in;
        st_nxt.bp_s2 = st_r.bp_s1;

        // Frame taken on the synchronised fall of chip enable; the shift
        // register is stable then because the control clock is idle
        frame_end = st_r.ce_s3 & ~st_r.ce_s2;
        addr_b = lnk_r.sr[7:0];
        cmd_b = lnk_r.sr[15:8];
        data_b = lnk_r.sr[23:16];
        cmd_ok = frame_end && addr_b == CHIP_ADDR && cmd_b[3:2] == 2'h0 && cmd_b[1:0] == CHIP_SUB;
        if (cmd_ok && cmd_b[7:4] == RXPS_CMD_PORT_SEL) begin
            st_nxt.port_sel = data_b;
            st_nxt.scan_ofs = 3'h0;
            st_nxt.scan_tmr = SCAN_LOAD;
        end
        if (cmd_ok && cmd_b[7:4] == RXPS_CMD_FMT_POL) begin
            st_nxt.fmt_pol = data_b;
        end

        // Unlock scan steps the input round the seven pins while unlocked
        base_sel = st_r.port_sel[RXPS_DSEL_LSB+:3];
        ulsw = st_r.port_sel[RXPS_ULSW_BIT];
        if (!ulsw || i_pll_locked || base_sel == RXPS_SEL_MOD) begin
            st_nxt.scan_ofs = 3'h0;
            st_nxt.scan_tmr = SCAN_LOAD;
        end else if (!cmd_ok) begin
            if (st_r.scan_tmr == '0) begin
                st_nxt.scan_tmr = SCAN_LOAD;
                st_nxt.scan_ofs = (st_r.scan_ofs == RXPS_LAST_PIN) ? 3'h0 : st_r.scan_ofs + 3'h1;
            end else begin
                st_nxt.scan_tmr = st_r.scan_tmr - TMR_W'(1);
            end
        end
        sum = {1'b0, base_sel} + {1'b0, st_r.scan_ofs};
        if (base_sel == RXPS_SEL_MOD) begin
            st_nxt.demod_sel = RXPS_SEL_MOD;
        end else if (sum > {1'b0, RXPS_LAST_PIN}) begin
            st_nxt.demod_sel = 3'(sum - 4'h7);
        end else begin
            st_nxt.demod_sel = sum[2:0];
        end
        st_nxt.demod_in = demod_mux(st_r.demod_sel, st_r.bp_s2, i_modulator_out, i_cfg);

        // Pass-through routing; shared pins 5 and 6 pass through whatever they carry
        psel = st_r.port_sel[RXPS_PSEL_LSB+:3];
        if (st_r.port_sel[RXPS_PDIS_BIT]) begin
            st_nxt.pt_out = 1'b0;
        end else if (psel == RXPS_SEL_MOD) begin
            st_nxt.pt_out = i_modulator_out;
        end else begin
            st_nxt.pt_out = st_r.bp_s2[psel];
        end

        // Output format; polarity bits except secondary bit-clock ride on top of any format
        fmt_code = st_r.fmt_pol[RXPS_OFMT_LSB+:3];
        st_nxt.fmt.format = fmt_code;
        st_nxt.fmt.format_valid = (fmt_code <= RXPS_FMT_LJ)
            || (fmt_code <= RXPS_FMT_RJ16 && i_cfg.master_mode);
        st_nxt.fmt.primary_bit_rise = st_r.fmt_pol[RXPS_PBCK_BIT];
        st_nxt.fmt.primary_ws_swap = st_r.fmt_pol[RXPS_PWS_BIT];
        st_nxt.fmt.secondary_bit_rise = 1'b0;
        st_nxt.fmt.secondary_ws_swap = st_r.fmt_pol[RXPS_SWS_BIT];

        // Clock source choice; crystal also whenever the PLL is unlocked
        force_xtal = i_cfg.clk_switch_method ? i_cfg.primary_clk_source_sel
                                             : i_cfg.out_clk_source_sel;
        want_xtal = force_xtal | ~i_pll_locked;
        unique case (st_r.cs)
            RXPS_CS_PLL: begin
                if (want_xtal) begin
                    st_nxt.tgt_xtal = 1'b1;
                    st_nxt.tmr = SWITCH_LOAD;
                    if (i_cfg.osc_amp_mode == RXPS_AMP_AUTO) begin
                        st_nxt.cs = RXPS_CS_WAIT_OSC;
                    end else begin
                        st_nxt.cs = RXPS_CS_SWITCH;
                    end
                end
            end
            RXPS_CS_WAIT_OSC: begin
                // Output keeps the PLL clock until the resonator has settled
                if (!want_xtal) begin
                    st_nxt.cs = RXPS_CS_PLL;
                end else if (i_osc_stable) begin
                    st_nxt.cs = RXPS_CS_SWITCH;
                end
            end
            RXPS_CS_SWITCH: begin
                if (st_r.tmr == '0) begin
                    st_nxt.clk_xtal = st_r.tgt_xtal;
                    st_nxt.data_serial = st_r.tgt_xtal;
                    st_nxt.cs = st_r.tgt_xtal ? RXPS_CS_XTAL : RXPS_CS_PLL;
                end else begin
                    st_nxt.tmr = st_r.tmr - TMR_W'(1);
                end
            end
            RXPS_CS_XTAL: begin
                if (!want_xtal) begin
                    st_nxt.tgt_xtal = 1'b0;
                    st_nxt.tmr = SWITCH_LOAD;
                    st_nxt.cs = RXPS_CS_SWITCH;
                end
            end
        endcase

        // Lock state passes through untouched by any source switch
        st_nxt.locked = i_pll_locked;

        // Error flag: switch error only when neither shielding setting is on
        keep_err = (i_cfg.osc_amp_mode == RXPS_AMP_CONT) | i_cfg.fs_change_error_mask;
        sw_err = (st_r.cs == RXPS_CS_SWITCH) & ~keep_err;
        st_nxt.err = i_base_error | (i_fs_change & ~i_cfg.fs_change_error_mask) | sw_err;

        if (!i_rst_n) begin
            st_nxt = '0;
            st_nxt.port_sel = RXPS_PORT_SEL_RST;
            st_nxt.fmt_pol = RXPS_FMT_POL_RST;
            st_nxt.cs = RXPS_CS_PLL;
            st_nxt.scan_tmr = SCAN_LOAD;
        end
    end

    always_ff @(posedge i_mclk) begin
        st_r <= st_nxt;
    end

    // Outputs straight from the state register
    assign o_demod_in = st_r.demod_in;
    assign o_demod_sel = st_r.demod_sel;
    assign o_passthrough_out = st_r.pt_out;
    assign o_fmt = st_r.fmt;
    assign o_clk_src_xtal = st_r.clk_xtal;
    assign o_data_src_serial = st_r.data_serial;
    assign o_serial_capture_sync = st_r.data_serial;
    assign o_receive_error_flag = st_r.err;
    assign o_pll_locked = st_r.locked;
    assign o_port_sel_reg = st_r.port_sel;
    assign o_fmt_pol_reg = st_r.fmt_pol;

endmodule

/* rxps_top_chk.sv */
// Checker for the port select and output format block, bound to its top.
// Assumes every relation is taken on i_mclk under the synchronous reset.
`timescale 1ns/1ns
module rxps_top_chk
    import rxps_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_modulator_out,
    input wire logic i_pll_locked,
    input wire logic i_fs_change,
    input wire logic i_base_error,
    input wire rxps_cfg_t i_cfg,
    input wire logic o_demod_in,
    input wire logic [2:0] o_demod_sel,
    input wire logic o_passthrough_out,
    input wire rxps_fmt_t o_fmt,
    input wire logic o_clk_src_xtal,
    input wire logic o_data_src_serial,
    input wire logic o_serial_capture_sync,
    input wire logic o_receive_error_flag,
    input wire logic o_pll_locked,
    input wire logic [7:0] o_port_sel_reg,
    input wire logic [7:0] o_fmt_pol_reg
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    logic live_r;
    logic shield;
    // Keeps the look-backs of the assertions that test it out of the reset period
    always_ff @(posedge i_mclk) begin
        live_r <= i_rst_n;
    end
    // Continuous amp or fs mask shields the flag from switching
    assign shield = i_cfg.osc_amp_mode == RXPS_AMP_CONT || i_cfg.fs_change_error_mask;
    dsel_follow_a: assert property (live_r && !$past(o_port_sel_reg[3]) |->
        o_demod_sel == $past(o_port_sel_reg[2:0])) else $error("demod select off");
    demod_mod_a: assert property (live_r && $past(o_demod_sel) == RXPS_SEL_MOD |->
        o_demod_in == $past(i_modulator_out)) else $error("demod modulator path");
    pt_low_a: assert property (live_r && $past(o_port_sel_reg[7])
        |-> !o_passthrough_out) else $error("pass-through not low");
    pt_mod_a: assert property (live_r && $past(o_port_sel_reg[7:4]) == 4'h7 |->
        o_passthrough_out == $past(i_modulator_out)) else $error("pass-through modulator");
    fmt_map_a: assert property (
        live_r |-> o_fmt[7:5] == $past(o_fmt_pol_reg[2:0]) &&
        o_fmt[3:0] == {$past(o_fmt_pol_reg[4]), $past(o_fmt_pol_reg[5]), 1'b0,
        $past(o_fmt_pol_reg[7])}) else $error("format fields off");
    fmt_valid_a: assert property (live_r |-> o_fmt.format_valid ==
        ($past(o_fmt_pol_reg[2:0]) < 3'h2 || ($past(o_fmt_pol_reg[2:0]) < 3'h5
        && $past(i_cfg.master_mode)))) else $error("format validity");
    err_shield_a: assert property (
        live_r && $past(shield) && !$past(i_base_error) &&
        !($past(i_fs_change) && !$past(i_cfg.fs_change_error_mask))
        |-> !o_receive_error_flag) else $error("error flag not shielded");
    err_switch_a: assert property (live_r && $changed(o_clk_src_xtal) && !$past(shield)
        |-> $past(o_receive_error_flag)) else $error("no error during switch");
    lock_keep_a: assert property (live_r |-> o_pll_locked == $past(i_pll_locked))
        else $error("lock state altered");
    data_clk_a: assert property (
        $changed(o_data_src_serial) |-> $changed(o_clk_src_xtal)
        && o_serial_capture_sync == o_data_src_serial) else $error("data and clock apart");
    cover property ($rose(o_clk_src_xtal));
    cover property ($rose(o_receive_error_flag));
    cover property (live_r && o_port_sel_reg[7]);
endmodule
bind rxps_top rxps_top_chk i_rxps_top_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_modulator_out(i_modulator_out), .i_pll_locked(i_pll_locked), .i_fs_change(i_fs_change),
    .i_base_error(i_base_error), .i_cfg(i_cfg), .o_demod_in(o_demod_in),
    .o_demod_sel(o_demod_sel), .o_passthrough_out(o_passthrough_out), .o_fmt(o_fmt),
    .o_clk_src_xtal(o_clk_src_xtal), .o_data_src_serial(o_data_src_serial),
    .o_serial_capture_sync(o_serial_capture_sync), .o_receive_error_flag(o_receive_error_flag),
    .o_pll_locked(o_pll_locked), .o_port_sel_reg(o_port_sel_reg), .o_fmt_pol_reg(o_fmt_pol_reg));

/* rxps_top_tb_top.sv */
// Self-checking bench for the port select and output format block.
// Assumes the host model owns the control port and its 125 ns link clock.
`timescale 1ns/1ns
module rxps_top_tb_top;
    import rxps_pkg::*;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [6:0] bip = 7'h00;
    logic modo = 1'b0, pll = 1'b1, osc = 1'b1, fsc = 1'b0, berr = 1'b0;
    rxps_cfg_t cfg = 9'h000;
    logic ctl_clk, ctl_ce, ctl_di, dmd, pto, xtal, dser, ssync, err, lck, e;
    logic [2:0] dsel;
    rxps_fmt_t fmt;
    logic [7:0] psr, fpr, ps, fp;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    rxps_host_model i_rxps_host_model (.o_ctl_clk(ctl_clk), .o_ctl_ce(ctl_ce), .o_ctl_di(ctl_di));
    rxps_top i_rxps_top (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ctl_clk(ctl_clk),
        .i_ctl_ce(ctl_ce), .i_ctl_di(ctl_di), .i_biphase_in(bip), .i_modulator_out(modo),
        .i_pll_locked(pll), .i_osc_stable(osc), .i_fs_change(fsc), .i_base_error(berr),
        .i_cfg(cfg), .o_demod_in(dmd), .o_demod_sel(dsel), .o_passthrough_out(pto),
        .o_fmt(fmt), .o_clk_src_xtal(xtal), .o_data_src_serial(dser),
        .o_serial_capture_sync(ssync), .o_receive_error_flag(err), .o_pll_locked(lck),
        .o_port_sel_reg(psr), .o_fmt_pol_reg(fpr));
    // Main clock, 100 ns
    initial begin
        forever #50 i_mclk = ~i_mclk;
    end
    // Cut a hang short; the whole run needs about 2800 cycles
    always @(posedge i_mclk) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            bad_count++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_val({7'h00, got}, {7'h00, exp});
    endtask
    // Selected demod data from the pins and modulator now held
    function automatic logic exp_dmd(input logic [2:0] c);
        if (c == RXPS_SEL_MOD) return modo;
        if (c == 3'h4 && cfg.validity_pin_option) return bip[5];
        if (c == 3'h5 && cfg.user_pin_option) return bip[6];
        return bip[c];
    endfunction
    function automatic logic [7:0] exp_fmt(input logic [7:0] f);
        return {f[2:0], f[2:0] < 3'h2 || (f[2:0] < 3'h5 && cfg.master_mode), f[4], f[5], 1'b0, f[7]};
    endfunction
    // Whole frame, then time for sync, register and output stage
    task automatic wr(input logic [7:0] a, input logic [3:0] c, input logic [7:0] d);
        i_rxps_host_model.send(a, {c, 4'h0}, d);
        repeat (4) @(posedge i_mclk);
        @(negedge i_mclk);
    endtask
    // Pins are held long enough to cover the three-cycle pin path
    task automatic path_chk();
        repeat (3) begin
            @(posedge i_mclk);
            bip <= 7'($urandom);
            modo <= 1'($urandom);
            repeat (5) @(negedge i_mclk);
            chk_bit(dmd, exp_dmd(ps[2:0]));
            chk_bit(pto, ps[7] ? 1'b0 : ps[6:4] == 3'h7 ? modo : bip[ps[6:4]]);
        end
    endtask
    // Bounded wait for a source change, noting any error flag on the way
    task automatic wait_src(input logic w);
        e = 1'b0;
        for (int i = 0; i < 40 && xtal !== w; i++) begin
            @(negedge i_mclk);
            e = e | err;
        end
        chk_bit(xtal, w);
        chk_bit(dser, w);
        chk_bit(ssync, w);
    endtask
    initial begin
        void'($urandom(77));
        repeat (4) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        repeat (3) @(negedge i_mclk);
        chk_val(psr, 8'h00);
        chk_val(fpr, 8'h00);
        chk_val(fmt, 8'h10);
        // Every demod and pass-through code, both pin options, random disable
        for (int k = 0; k < 16; k++) begin
            @(posedge i_mclk);
            cfg.validity_pin_option <= k[3];
            cfg.user_pin_option <= k[3];
            // Disable only on odd passes so the modulator pass-through code is reached
            ps = {1'($urandom) & k[0], 3'(7 - k), 1'b0, 3'(k)};
            wr(8'hE8, RXPS_CMD_PORT_SEL, ps);
            chk_val(psr, ps);
            chk_val({5'h00, dsel}, {5'h00, ps[2:0]});
            path_chk();
        end
        // A foreign chip address is ignored
        wr(8'hE9, RXPS_CMD_PORT_SEL, 8'h5A);
        chk_val(psr, ps);
        // Every format code in slave and master mode, random polarities
        for (int k = 0; k < 16; k++) begin
            @(posedge i_mclk);
            cfg.master_mode <= k[3];
            fp = {4'($urandom), 1'b0, 3'(k)};
            wr(8'hE8, RXPS_CMD_FMT_POL, fp);
            chk_val(fpr, fp);
            chk_val(fmt, exp_fmt(fp));
        end
        // Data source follows the clock source through every switch
        @(posedge i_mclk);
        cfg.osc_amp_mode <= RXPS_AMP_CONT;
        cfg.out_clk_source_sel <= 1'b1;
        wait_src(1'b1);
        chk_bit(e, 1'b0);
        chk_bit(lck, 1'b1);
        @(posedge i_mclk);
        cfg.osc_amp_mode <= RXPS_AMP_AUTO;
        cfg.out_clk_source_sel <= 1'b0;
        wait_src(1'b0);
        chk_bit(e, 1'b1);
        @(posedge i_mclk);
        osc <= 1'b0;
        cfg.fs_change_error_mask <= 1'b1;
        cfg.out_clk_source_sel <= 1'b1;
        repeat (30) @(negedge i_mclk);
        chk_bit(xtal, 1'b0);
        @(posedge i_mclk);
        osc <= 1'b1;
        wait_src(1'b1);
        chk_bit(e, 1'b0);
        @(posedge i_mclk);
        cfg.fs_change_error_mask <= 1'b0;
        cfg.out_clk_source_sel <= 1'b0;
        wait_src(1'b0);
        chk_bit(e, 1'b1);
        @(posedge i_mclk);
        pll <= 1'b0;
        wait_src(1'b1);
        @(posedge i_mclk);
        pll <= 1'b1;
        wait_src(1'b0);
        // Second select bit takes over when the switch method says so
        @(posedge i_mclk);
        cfg.clk_switch_method <= 1'b1;
        cfg.primary_clk_source_sel <= 1'b1;
        wait_src(1'b1);
        @(posedge i_mclk);
        cfg.primary_clk_source_sel <= 1'b0;
        wait_src(1'b0);
        chk_bit(e, 1'b1);
        // Fs change reaches the flag unless masked; other errors reach it always
        for (int k = 0; k < 4; k++) begin
            @(posedge i_mclk);
            fsc <= 1'b1;
            cfg.fs_change_error_mask <= k[0];
            berr <= k[1];
            repeat (2) @(negedge i_mclk);
            chk_bit(err, !k[0] || k[1]);
        end
        // Unlock scan, enabled by the unlock switch bit; the amp runs continuously here
        @(posedge i_mclk);
        fsc <= 1'b0;
        berr <= 1'b0;
        cfg.osc_amp_mode <= RXPS_AMP_CONT;
        wr(8'hE8, RXPS_CMD_PORT_SEL, 8'h08);
        chk_val({5'h00, dsel}, 8'h00);
        @(posedge i_mclk);
        pll <= 1'b0;
        for (int i = 0; i < 1100 && dsel !== 3'h1; i++) begin
            @(negedge i_mclk);
        end
        chk_val({5'h00, dsel}, 8'h01);
        // Reset in mid-run clears the port select register and stops the scan
        @(posedge i_mclk);
        i_rst_n <= 1'b0;
        repeat (4) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        repeat (3) @(negedge i_mclk);
        chk_val(psr, 8'h00);
        chk_val({5'h00, dsel}, 8'h00);
        finish_test();
    end
endmodule
